// file: hw/pwm_common_ctrl.sv
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "pwm_common_params.svh"
// Function
// RULE_01: ready flag shown in top bit of clock control register.
// RULE_02: error bit sets on fine edge fault; full resolution needs ready and no error.
// RULE_03: lock set blocks writes to protected registers and bits.
// RULE_04: lock clears only after the unlock sequence; otherwise ignored.
// RULE_05: divider field 00/01/10/11 divides by 2/4/8/16.
// RULE_06: select field picks aux pll, primary pll, aux vco/2 or oscillator.
// RULE_07: software avoids changing clock select while a generator runs.
// RULE_08: increment added to accumulator every master clock cycle.
// RULE_09: scaled pulse emitted when accumulator exceeds minimum period.
// RULE_10: minimum period register holds the shortest scaled period.
// RULE_11: sixteen-bit shared phase register for all generators.
// RULE_12: sixteen-bit shared duty register for all generators.
// RULE_13: software keeps duty at least 0x0008, or 0x0020 in fine mode.
// RULE_14: eight generators with two outputs each share these resources.
// RULE_15: unimplemented clock control bits read zero, ignore writes.
// RULE_16: after a pulse minimum period is subtracted, keeping the remainder; the code caps a remainder above FSCALE_SAT at FSCALE_SAT.
// RULE_17: all common registers reset to zero.
module pwm_common_ctrl #(
  parameter int NUM_GEN = 8
) (
  // clock and reset
  input  wire logic                      core_clk_in,
  input  wire logic                      rst_in,
  // register port
  input  wire pwm_common_pkg::reg_req_t  reg_req_in,
  output logic [15:0]                    reg_rdata_out,
  // fine edge circuitry status
  input  wire logic                      fine_edge_ready_in,
  input  wire logic                      fine_edge_fault_in,
  // clock and shared values to generators
  output logic [1:0]                     master_clock_select_out,
  output logic [NUM_GEN-1:0]             gen_clk_tick_out,
  output logic                           scaled_clk_out,
  output logic [15:0]                    shared_phase_value_out,
  output logic [15:0]                    shared_duty_value_out,
  output logic                           full_resolution_out,
  output logic                           lock_out,
  // interrupt
  output logic                           irq_out
);

  // ---------------------------------------------
  // state
  // ---------------------------------------------
  pwm_common_pkg::clk_ctrl_t     ctrl;
  pwm_common_pkg::unlock_state_t unlock_st;
  logic [15:0]          freq_scale_increment;
  logic [15:0]          freq_scale_min_period;
  logic [15:0]          shared_phase_value;
  logic [15:0]          shared_duty_value;
  logic [NUM_GEN-1:0]   gen_enable;
  logic [`IRQ_BITS-1:0] irq_status;
  logic [`IRQ_BITS-1:0] irq_mask;
  logic [2:0]           rdy_sync;
  logic [2:0]           flt_sync;
  logic                 fine_edge_ready;
  logic                 fine_edge_fault;
  logic                 fine_edge_error;
  logic [3:0]           div_count;
  logic [17:0]          fscale_acc;
  logic [17:0]          next_acc;
  logic                 next_pulse;
  logic                 wr_en;
  logic                 blocked_wr;
  logic                 ready_rise;
  logic                 lock_clear_ok;

  // decoded write to one offset
  function automatic logic hit(input logic [3:0] ofs);
    return reg_req_in.wr && (reg_req_in.addr == ofs);
  endfunction

  // divider terminal mask: 1, 3, 7 or 15 gives 2, 4, 8, 16
  function automatic logic [3:0] div_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    return 4'h1;
      2'h1:    return 4'h3;
      2'h2:    return 4'h7;
      default: return 4'hf;
    endcase
  endfunction

  assign wr_en         = reg_req_in.wr;
  // protected targets: clock selection fields and generator enables
  // spelled out: a function reading the port would hide it from this assignment
  assign blocked_wr    = ctrl.lock && reg_req_in.wr &&
                         (reg_req_in.addr == `OFS_CLK_CTRL ||
                          reg_req_in.addr == `OFS_GEN_ENABLE); // [RULE_03]
  assign lock_clear_ok = (unlock_st == pwm_common_pkg::UNLK_ARMED);

  // ---------------------------------------------
  // input synchronisers
  // ---------------------------------------------
  // three stages; a level counts once stages two and three agree
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rdy_sync <= 3'h0;
      flt_sync <= 3'h0;
    end else begin
      rdy_sync <= {rdy_sync[1:0], fine_edge_ready_in};
      flt_sync <= {flt_sync[1:0], fine_edge_fault_in};
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      fine_edge_ready <= 1'b0;
      fine_edge_fault <= 1'b0;
    end else begin
      if (rdy_sync[1] == rdy_sync[2]) begin
        fine_edge_ready <= rdy_sync[2];
      end
      if (flt_sync[1] == flt_sync[2]) begin
        fine_edge_fault <= flt_sync[2];
      end
    end
  end

  assign ready_rise = (rdy_sync[1] == rdy_sync[2]) && rdy_sync[2] && !fine_edge_ready;

  // ---------------------------------------------
  // unlock sequence
  // ---------------------------------------------
  // two key writes arm; the next write consumes it, whatever its offset
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      unlock_st <= pwm_common_pkg::UNLK_IDLE;
    end else if (hit(`OFS_UNLOCK)) begin
      case (unlock_st)
        pwm_common_pkg::UNLK_IDLE:
          unlock_st <= (reg_req_in.wdata == `UNLOCK_KEY_A) ?
                       pwm_common_pkg::UNLK_HALF : pwm_common_pkg::UNLK_IDLE;
        pwm_common_pkg::UNLK_HALF:
          unlock_st <= (reg_req_in.wdata == `UNLOCK_KEY_B) ?
                       pwm_common_pkg::UNLK_ARMED : pwm_common_pkg::UNLK_IDLE;
        default:
          unlock_st <= pwm_common_pkg::UNLK_IDLE;
      endcase
    end else if (wr_en) begin
      // any other write breaks the sequence
      unlock_st <= pwm_common_pkg::UNLK_IDLE; // [RULE_04]
    end
  end

  // ---------------------------------------------
  // clock control register
  // ---------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ctrl <= '0; // [RULE_17]
    end else if (hit(`OFS_CLK_CTRL)) begin
      // setting the lock is always allowed, clearing needs the sequence
      if (reg_req_in.wdata[`BIT_LOCK]) begin
        ctrl.lock <= 1'b1;
      end else if (lock_clear_ok) begin
        ctrl.lock <= 1'b0; // [RULE_04]
      end
      if (!ctrl.lock) begin
        ctrl.clock_divider_select <= reg_req_in.wdata[`DIV_HI:`DIV_LO]; // [RULE_05]
        ctrl.master_clock_select  <= reg_req_in.wdata[`MSEL_HI:`MSEL_LO]; // [RULE_06]
      end
    end
  end

  // error is sticky; a fault in the clearing cycle wins
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      fine_edge_error <= 1'b0;
    end else if (fine_edge_fault) begin
      fine_edge_error <= 1'b1; // [RULE_02]
    end else if (hit(`OFS_CLK_CTRL) && reg_req_in.wdata[`BIT_ERROR]) begin
      fine_edge_error <= 1'b0;
    end
  end

  // ---------------------------------------------
  // data registers
  // ---------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      freq_scale_increment  <= `RST_WORD; // [RULE_17]
      freq_scale_min_period <= `RST_WORD;
      shared_phase_value    <= `RST_WORD;
      shared_duty_value     <= `RST_WORD;
    end else begin
      if (hit(`OFS_FSCALE_INC)) begin
        freq_scale_increment <= reg_req_in.wdata;
      end
      if (hit(`OFS_FSCALE_MIN)) begin
        freq_scale_min_period <= reg_req_in.wdata; // [RULE_10]
      end
      if (hit(`OFS_PHASE)) begin
        shared_phase_value <= reg_req_in.wdata; // [RULE_11]
      end
      if (hit(`OFS_DUTY)) begin
        shared_duty_value <= reg_req_in.wdata; // [RULE_12]
      end
    end
  end

  // generator enables are write protected by the lock
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      gen_enable <= '0;
    end else if (hit(`OFS_GEN_ENABLE) && !ctrl.lock) begin
      gen_enable <= reg_req_in.wdata[NUM_GEN-1:0]; // [RULE_03]
    end
  end

  // ---------------------------------------------
  // clock divider
  // ---------------------------------------------
  // free running count; generators get one tick per divided period
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      div_count        <= 4'h0;
      gen_clk_tick_out <= '0;
    end else begin
      if ((div_count & div_mask(ctrl.clock_divider_select)) ==
          div_mask(ctrl.clock_divider_select)) begin
        div_count        <= 4'h0;
        gen_clk_tick_out <= gen_enable; // [RULE_05] [RULE_14]
      end else begin
        div_count        <= div_count + 4'h1;
        gen_clk_tick_out <= '0;
      end
    end
  end

  // ---------------------------------------------
  // frequency scaling accumulator
  // ---------------------------------------------
  // wide sum keeps carries; remainder saturates so it can never wrap
  always_comb begin
    next_acc   = fscale_acc + {2'h0, freq_scale_increment}; // [RULE_08]
    next_pulse = next_acc > {2'h0, freq_scale_min_period}; // [RULE_09]
    if (next_pulse) begin
      next_acc = next_acc - {2'h0, freq_scale_min_period}; // [RULE_16]
    end
    if (next_acc > `FSCALE_SAT) begin
      next_acc = `FSCALE_SAT;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      fscale_acc     <= 18'h0;
      scaled_clk_out <= 1'b0;
    end else begin
      fscale_acc     <= next_acc;
      scaled_clk_out <= next_pulse;
    end
  end

  // ---------------------------------------------
  // interrupts
  // ---------------------------------------------
  // write one clears; a new event in the same cycle wins
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      irq_status <= '0;
      irq_mask   <= '0;
    end else begin
      if (hit(`OFS_IRQ_MASK)) begin
        irq_mask <= reg_req_in.wdata[`IRQ_BITS-1:0];
      end
      irq_status <= (irq_status &
                     ~(hit(`OFS_IRQ_STATUS) ? reg_req_in.wdata[`IRQ_BITS-1:0] : '0)) |
                    {blocked_wr, ready_rise, fine_edge_fault, next_pulse};
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_status & irq_mask);
    end
  end

  // ---------------------------------------------
  // outputs and read port
  // ---------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      master_clock_select_out <= 2'h0;
      shared_phase_value_out  <= `RST_WORD;
      shared_duty_value_out   <= `RST_WORD;
      full_resolution_out     <= 1'b0;
      lock_out                <= 1'b0;
    end else begin
      master_clock_select_out <= ctrl.master_clock_select; // [RULE_06]
      shared_phase_value_out  <= shared_phase_value;
      shared_duty_value_out   <= shared_duty_value;
      full_resolution_out     <= fine_edge_ready && !fine_edge_error; // [RULE_02]
      lock_out                <= ctrl.lock;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= `RST_WORD;
    end else if (reg_req_in.rd) begin
      reg_rdata_out <= `RST_WORD;
      case (reg_req_in.addr)
        `OFS_CLK_CTRL: begin
          // unlisted positions stay zero
          reg_rdata_out[`BIT_READY]         <= fine_edge_ready; // [RULE_01] [RULE_15]
          reg_rdata_out[`BIT_ERROR]         <= fine_edge_error;
          reg_rdata_out[`BIT_LOCK]          <= ctrl.lock;
          reg_rdata_out[`DIV_HI:`DIV_LO]    <= ctrl.clock_divider_select;
          reg_rdata_out[`MSEL_HI:`MSEL_LO]  <= ctrl.master_clock_select;
        end
        `OFS_FSCALE_INC: reg_rdata_out <= freq_scale_increment;
        `OFS_FSCALE_MIN: reg_rdata_out <= freq_scale_min_period;
        `OFS_PHASE:      reg_rdata_out <= shared_phase_value;
        `OFS_DUTY:       reg_rdata_out <= shared_duty_value;
        `OFS_IRQ_STATUS: reg_rdata_out[`IRQ_BITS-1:0] <= irq_status;
        `OFS_IRQ_MASK:   reg_rdata_out[`IRQ_BITS-1:0] <= irq_mask;
        `OFS_GEN_ENABLE: reg_rdata_out[NUM_GEN-1:0]   <= gen_enable;
        default:         reg_rdata_out <= `RST_WORD;
      endcase
    end else begin
      reg_rdata_out <= `RST_WORD;
    end
  end

  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  a_lock_blocks_div: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE_03]
    ctrl.lock && reg_req_in.wr && reg_req_in.addr == `OFS_CLK_CTRL
    |=> $stable(ctrl.clock_divider_select))
    else $error("divider changed while locked");

  a_lock_clear_seq: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE_04]
    $fell(ctrl.lock) |-> $past(unlock_st) == pwm_common_pkg::UNLK_ARMED)
    else $error("lock cleared without unlock");

  a_ready_read: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE_01]
    reg_req_in.rd && reg_req_in.addr == `OFS_CLK_CTRL
    |=> reg_rdata_out[`BIT_READY] == $past(fine_edge_ready))
    else $error("ready bit misread");

  a_unimpl_zero: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE_15]
    reg_req_in.rd && reg_req_in.addr == `OFS_CLK_CTRL
    |=> reg_rdata_out[13:9] == 5'h0 && reg_rdata_out[7:6] == 2'h0 &&
        reg_rdata_out[3:2] == 2'h0)
    else $error("unimplemented bit nonzero");

  a_error_sticky: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE_02]
    fine_edge_fault |=> fine_edge_error ##1 !full_resolution_out)
    else $error("fault did not set error");

  a_div_ratio: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE_05]
    gen_clk_tick_out[0] && ctrl.clock_divider_select == 2'h0 && $stable(ctrl)
    |=> !gen_clk_tick_out[0] ##1 (gen_clk_tick_out[0] == $past(gen_enable[0])))
    else $error("divide by two period wrong");

  a_acc_adds: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE_08]
    !next_pulse && next_acc < `FSCALE_SAT
    |=> fscale_acc == $past(fscale_acc) + {2'h0, $past(freq_scale_increment)})
    else $error("accumulator did not add");

  a_scaled_pulse: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE_09]
    fscale_acc + {2'h0, freq_scale_increment} > {2'h0, freq_scale_min_period}
    |=> scaled_clk_out)
    else $error("scaled pulse missing");

  a_remainder: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE_16]
    next_pulse && next_acc < `FSCALE_SAT |=> fscale_acc == $past(fscale_acc) +
    {2'h0, $past(freq_scale_increment)} - {2'h0, $past(freq_scale_min_period)})
    else $error("remainder not kept");

  a_duty_path: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RULE_12]
    reg_req_in.wr && reg_req_in.addr == `OFS_DUTY
    |=> ##1 shared_duty_value_out == $past(reg_req_in.wdata, 2))
    else $error("shared duty not forwarded");

endmodule

// file: hw/pwm_common_params.svh
`ifndef PWM_COMMON_PARAMS_SVH
`define PWM_COMMON_PARAMS_SVH
// ---------------------------------------------
// register offsets
// ---------------------------------------------
`define OFS_CLK_CTRL    4'h0
`define OFS_FSCALE_INC  4'h1
`define OFS_FSCALE_MIN  4'h2
`define OFS_PHASE       4'h3
`define OFS_DUTY        4'h4
`define OFS_IRQ_STATUS  4'h5
`define OFS_IRQ_MASK    4'h6
`define OFS_UNLOCK      4'h7
`define OFS_GEN_ENABLE  4'h8
// ---------------------------------------------
// clock control field positions
// ---------------------------------------------
`define BIT_READY       15
`define BIT_ERROR       14
`define BIT_LOCK        8
`define DIV_HI          5
`define DIV_LO          4
`define MSEL_HI         1
`define MSEL_LO         0
// ---------------------------------------------
// interrupt status bits
// ---------------------------------------------
`define IRQ_SCALED      0
`define IRQ_ERROR       1
`define IRQ_READY       2
`define IRQ_BLOCKED     3
`define IRQ_BITS        4
// ---------------------------------------------
// values
// ---------------------------------------------
`define RST_WORD        16'h0000
`define UNLOCK_KEY_A    16'h55aa
`define UNLOCK_KEY_B    16'haa55
`define FSCALE_SAT      18'h0ffff
`endif

// file: hw/pwm_common_pkg.sv
package pwm_common_pkg;
  // register port request, one cycle wide
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;
  // writable fields of the clock control register
  typedef struct packed {
    logic       lock;
    logic [1:0] clock_divider_select;
    logic [1:0] master_clock_select;
  } clk_ctrl_t;
  // unlock sequence progress
  typedef enum logic [1:0] {UNLK_IDLE, UNLK_HALF, UNLK_ARMED} unlock_state_t;
endpackage

// file: sim/fine_edge_model.sv
`timescale 1ns/100ps
// ---------------------------------------------
// fine edge circuitry stand-in
// ---------------------------------------------
module fine_edge_model #(
  parameter int READY_DELAY = 40
) (
  // clock and reset
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  // fault request from the bench
  input  wire logic fault_cmd_in,
  // status towards the block
  output logic      fine_edge_ready_out,
  output logic      fine_edge_fault_out
);
  int unsigned count;
  // ready only after a calibration delay, so the bench sees it low right after reset
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      count               <= 0;
      fine_edge_ready_out <= 1'b0;
    end else if (count < READY_DELAY) begin
      count <= count + 1;
    end else begin
      fine_edge_ready_out <= 1'b1;
    end
  end
  // fault follows the command one cycle late, like a registered detector
  always_ff @(posedge core_clk_in) begin
    fine_edge_fault_out <= rst_in ? 1'b0 : fault_cmd_in;
  end
endmodule

// file: sim/pwm_common_clock_master_values_bench.sv
`timescale 1ns/100ps
`include "pwm_common_params.svh"
module pwm_common_clock_master_values_bench;
  // ---------------------------------------------
  // signals
  // ---------------------------------------------
  logic                     core_clk;
  logic                     rst;
  pwm_common_pkg::reg_req_t req;
  logic [15:0]              rdata;
  logic                     fault_cmd;
  logic                     ready;
  logic                     fault;
  logic [1:0]               msel;
  logic [7:0]               tick;
  logic                     scaled;
  logic                     full_res;
  logic                     lock;
  logic                     irq;
  logic [15:0]              phase;
  logic [15:0]              duty;
  logic                     sel_scaled;
  int                       cnt;
  int                       n_mismatch = 0;
  int                       checks = 0;
  wire                      watch = sel_scaled ? scaled : tick[0];

  pwm_common_ctrl #(.NUM_GEN(8)) dut_u (
    .core_clk_in             (core_clk),
    .rst_in                  (rst),
    .reg_req_in              (req),
    .reg_rdata_out           (rdata),
    .fine_edge_ready_in      (ready),
    .fine_edge_fault_in      (fault),
    .master_clock_select_out (msel),
    .gen_clk_tick_out        (tick),
    .scaled_clk_out          (scaled),
    .shared_phase_value_out  (phase),
    .shared_duty_value_out   (duty),
    .full_resolution_out     (full_res),
    .lock_out                (lock),
    .irq_out                 (irq)
  );

  fine_edge_model #(.READY_DELAY(40)) model_u (
    .core_clk_in         (core_clk),
    .rst_in              (rst),
    .fault_cmd_in        (fault_cmd),
    .fine_edge_ready_out (ready),
    .fine_edge_fault_out (fault)
  );

  // ---------------------------------------------
  // clock and access tasks
  // ---------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1 check(rdata, exp);
  endtask

  // skips two pulses so a fresh setting has settled, then times one gap
  task automatic gap(input int exp);
    int n;
    repeat (3) begin
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
      end while (!watch && n < 200);
    end
    check(16'(n), 16'(exp));
  endtask

  task automatic results();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // a hung handshake must not stall the run
  initial begin
    #(20000 * 4);
    n_mismatch++;
    results();
  end

  // ---------------------------------------------
  // test sequence
  // ---------------------------------------------
  initial begin
    req        = '0;
    fault_cmd  = 1'b0;
    sel_scaled = 1'b0;
    rst        = 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    for (int a = 0; a < 7; a++) rd(4'(a), 16'h0000);
    repeat (60) @(posedge core_clk);
    rd(`OFS_CLK_CTRL, 16'h8000);
    check({15'h0, full_res}, 16'h0001);
    wr(`OFS_CLK_CTRL, 16'h3ecc);
    rd(`OFS_CLK_CTRL, 16'h8000);
    wr(`OFS_DUTY, 16'h0020);
    wr(`OFS_PHASE, 16'ha5c3);
    rd(`OFS_PHASE, 16'ha5c3);
    rd(`OFS_DUTY, 16'h0020);
    check(phase, 16'ha5c3);
    check(duty, 16'h0020);
    // scaler: period is min/inc when it divides evenly
    sel_scaled = 1'b1;
    wr(`OFS_FSCALE_INC, 16'h0001);
    wr(`OFS_FSCALE_MIN, 16'h0003);
    rd(`OFS_FSCALE_MIN, 16'h0003);
    repeat (50) @(posedge core_clk);
    gap(3);
    wr(`OFS_FSCALE_INC, 16'h0010);
    wr(`OFS_FSCALE_MIN, 16'h0040);
    repeat (20) @(posedge core_clk);
    gap(4);
    wr(`OFS_FSCALE_INC, 16'h0000);
    // the pulse launched with the old increment may still be standing
    repeat (2) @(posedge core_clk);
    cnt = 0;
    repeat (40) begin
      @(posedge core_clk);
      cnt += int'(scaled);
    end
    check(16'(cnt), 16'h0000);
    // interrupt: scaled pulse and ready rise are pending, nothing unmasked yet
    rd(`OFS_IRQ_STATUS, 16'h0005);
    check({15'h0, irq}, 16'h0000);
    wr(`OFS_IRQ_MASK, 16'h0001);
    repeat (2) @(posedge core_clk);
    #1 check({15'h0, irq}, 16'h0001);
    wr(`OFS_IRQ_STATUS, 16'h0001);
    repeat (3) @(posedge core_clk);
    #1 check({15'h0, irq}, 16'h0000);
    rd(`OFS_IRQ_STATUS, 16'h0004);
    // divider: generators stopped while the clock choice changes
    sel_scaled = 1'b0;
    for (int d = 0; d < 4; d++) begin
      wr(`OFS_GEN_ENABLE, 16'h0000);
      wr(`OFS_CLK_CTRL, 16'(d * 17));
      wr(`OFS_GEN_ENABLE, 16'h00ff);
      rd(`OFS_CLK_CTRL, 16'h8000 | 16'(d * 17));
      check({14'h0, msel}, 16'(d));
      gap(2 << d);
      check({8'h0, tick}, 16'h00ff);
    end
    wr(`OFS_GEN_ENABLE, 16'h0000);
    // lock: protected fields and the enable register refuse writes
    wr(`OFS_IRQ_STATUS, 16'h000f);
    wr(`OFS_CLK_CTRL, 16'h0112);
    rd(`OFS_CLK_CTRL, 16'h8112);
    check({15'h0, lock}, 16'h0001);
    wr(`OFS_CLK_CTRL, 16'h0033);
    rd(`OFS_CLK_CTRL, 16'h8112);
    wr(`OFS_GEN_ENABLE, 16'h00ff);
    rd(`OFS_GEN_ENABLE, 16'h0000);
    rd(`OFS_IRQ_STATUS, 16'h0008);
    wr(`OFS_UNLOCK, 16'h55aa);
    wr(`OFS_UNLOCK, 16'haa55);
    wr(`OFS_CLK_CTRL, 16'h0033);
    rd(`OFS_CLK_CTRL, 16'h8012);
    wr(`OFS_CLK_CTRL, 16'h0033);
    rd(`OFS_CLK_CTRL, 16'h8033);
    // an interrupted key sequence must not unlock
    wr(`OFS_CLK_CTRL, 16'h0133);
    wr(`OFS_UNLOCK, 16'h55aa);
    wr(`OFS_PHASE, 16'h1234);
    wr(`OFS_UNLOCK, 16'haa55);
    wr(`OFS_CLK_CTRL, 16'h0033);
    rd(`OFS_CLK_CTRL, 16'h8133);
    wr(`OFS_UNLOCK, 16'h55aa);
    wr(`OFS_UNLOCK, 16'haa55);
    wr(`OFS_CLK_CTRL, 16'h0000);
    rd(`OFS_CLK_CTRL, 16'h8033);
    // fault: sticky error, resolution drops until cleared
    wr(`OFS_IRQ_STATUS, 16'h000f);
    fault_cmd <= 1'b1;
    repeat (10) @(posedge core_clk);
    rd(`OFS_CLK_CTRL, 16'hc033);
    check({15'h0, full_res}, 16'h0000);
    fault_cmd <= 1'b0;
    repeat (10) @(posedge core_clk);
    rd(`OFS_CLK_CTRL, 16'hc033);
    wr(`OFS_CLK_CTRL, 16'h4033);
    rd(`OFS_CLK_CTRL, 16'h8033);
    repeat (3) @(posedge core_clk);
    #1 check({15'h0, full_res}, 16'h0001);
    rd(`OFS_IRQ_STATUS, 16'h0002);
    // unmapped place: reads zero, write lands nowhere
    wr(4'hf, 16'hffff);
    rd(4'hf, 16'h0000);
    rd(`OFS_PHASE, 16'h1234);
    results();
  end
endmodule
